// *** src/pvt_map.svh ***
// Timing and power-sequence constants for the panel host controller
`ifndef PVT_MAP_SVH
`define PVT_MAP_SVH

`define PVT_CLK_HZ 100000000
`define PVT_LINE_ACTIVE 1280
`define PVT_LINE_TOTAL 1440
`define PVT_LINE_TOTAL_MIN 1360
`define PVT_LINE_TOTAL_MAX 1900
`define PVT_FRAME_ACTIVE 800
`define PVT_FRAME_TOTAL 823
`define PVT_FRAME_TOTAL_MIN 810
`define PVT_FRAME_TOTAL_MAX 1900
`define PVT_COLOUR_BITS 6
`define PVT_T1_US 1000
`define PVT_T2_US 10000
`define PVT_T3_US 10000
`define PVT_T4_US 500000
`define PVT_T5_US 200000
`define PVT_T6_US 200000
`define PVT_US_TO_CYC(us) ((us) * (`PVT_CLK_HZ / 1000000))

`endif

// *** src/pvt_pkg.sv ***
// Types for the panel host controller
package pvt_pkg;
  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } pvt_pixel_t;

  typedef enum {
    PVT_OFF, PVT_T1, PVT_VIDEO_ON, PVT_T2, PVT_LIGHT_ON, PVT_T3, PVT_VIDEO_OFF, PVT_T4
  } pvt_state_t;
endpackage

// *** src/pvt_fifo.sv ***
// Pixel FIFO crossing from the system clock to the pixel clock
module pvt_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // Write side
  input wire logic wr_clk_in,
  input wire logic wr_rst_b_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Read side
  input wire logic rd_clk_in,
  input wire logic rd_rst_b_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) $error("pvt_fifo depth must be a power of two");
  end

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_reg, wp_next, wg_reg, rp_reg, rp_next, rg_reg;
  logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
  logic wr_go, rd_go;

  always_comb begin
    wr_ready_out = wg_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
    rd_valid_out = rg_reg != wg_s2_reg;
    wr_go = wr_valid_in && wr_ready_out;
    rd_go = rd_ready_in && rd_valid_out;
    wp_next = wp_reg + (AW+1)'(wr_go);
    rp_next = rp_reg + (AW+1)'(rd_go);
    rd_data_out = mem[rp_reg[AW-1:0]];
  end

  always_ff @(posedge wr_clk_in) begin
    if (wr_go) mem[wp_reg[AW-1:0]] <= wr_data_in;
  end

  always_ff @(posedge wr_clk_in) begin
    if (!wr_rst_b_in) begin
      wp_reg <= '0;
      wg_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      wg_reg <= to_gray(wp_next);
      rg_s1_reg <= rg_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  always_ff @(posedge rd_clk_in) begin
    if (!rd_rst_b_in) begin
      rp_reg <= '0;
      rg_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      rp_reg <= rp_next;
      rg_reg <= to_gray(rp_next);
      wg_s1_reg <= wg_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end
endmodule

// *** src/pvt_host.sv ***
// Host side: power sequencer on the system clock, video timing on the pixel clock
`include "pvt_map.svh"
module pvt_host #(
  parameter int LINE_ACTIVE = `PVT_LINE_ACTIVE,
  parameter int LINE_TOTAL = `PVT_LINE_TOTAL,
  parameter int FRAME_ACTIVE = `PVT_FRAME_ACTIVE,
  parameter int FRAME_TOTAL = `PVT_FRAME_TOTAL,
  parameter int FIFO_DEPTH = 32,
  parameter int T1_CYC = `PVT_US_TO_CYC(`PVT_T1_US),
  parameter int T2_CYC = `PVT_US_TO_CYC(`PVT_T2_US),
  parameter int T3_CYC = `PVT_US_TO_CYC(`PVT_T3_US),
  parameter int T4_CYC = `PVT_US_TO_CYC(`PVT_T4_US),
  parameter int T5_CYC = `PVT_US_TO_CYC(`PVT_T5_US),
  parameter int T6_CYC = `PVT_US_TO_CYC(`PVT_T6_US)
) (
  // System clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  // Panel link clock
  input wire logic PIXEL_CLOCK_IN,
  // Control and status
  input wire logic PANEL_ENABLE_IN,
  output logic PANEL_READY_OUT,
  // Pixel stream in
  input wire logic PIX_VALID_IN,
  output logic PIX_READY_OUT,
  input wire pvt_pkg::pvt_pixel_t PIX_DATA_IN,
  // Panel pins
  output logic LOGIC_SUPPLY_ON_OUT,
  output logic BACKLIGHT_ON_OUT,
  output logic ACTIVE_VIDEO_QUALIFIER_OUT,
  output pvt_pkg::pvt_pixel_t PIXEL_DATA_OUT
);
  initial begin
    if (LINE_TOTAL < `PVT_LINE_TOTAL_MIN || LINE_TOTAL > `PVT_LINE_TOTAL_MAX
        || LINE_ACTIVE != `PVT_LINE_ACTIVE) $error("pvt_host line timing out of range");
    if (FRAME_TOTAL < `PVT_FRAME_TOTAL_MIN || FRAME_TOTAL > `PVT_FRAME_TOTAL_MAX
        || FRAME_ACTIVE != `PVT_FRAME_ACTIVE) $error("pvt_host frame timing out of range");
    if (T1_CYC < 1 || T2_CYC < 1 || T3_CYC < 1 || T4_CYC < 1 || T5_CYC < 1 || T6_CYC < 1)
      $error("pvt_host sequence counts must be positive");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer (system clock)
  pvt_pkg::pvt_state_t st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] off_cnt_reg, off_cnt_next;
  logic sup_reg, sup_next, vid_reg, vid_next, bl_reg, bl_next, rdy_reg, rdy_next;
  logic en_s1_reg, en_s2_reg;
  logic pix_rdy;
  // Pixel side still driving enable or data, carried back across to this clock
  logic live_reg, live_s1_reg, live_s2_reg;

  function automatic logic [31:0] longer(input int a, input int b);
    return 32'(a > b ? a : b);
  endfunction

  always_comb begin
    st_next = st_reg;
    cnt_next = (cnt_reg == 32'h0) ? 32'h0 : cnt_reg - 32'h1;
    off_cnt_next = (off_cnt_reg == 32'h0) ? 32'h0 : off_cnt_reg - 32'h1;
    sup_next = sup_reg;
    vid_next = vid_reg;
    bl_next = bl_reg;
    rdy_next = 1'b0;
    unique case (st_reg)
      pvt_pkg::PVT_OFF: begin
        // Off-time t4 must pass before the supply returns
        if (en_s2_reg && off_cnt_reg == 32'h0) begin
          sup_next = 1'b1;
          cnt_next = 32'(T1_CYC);
          st_next = pvt_pkg::PVT_T1;
        end
      end
      pvt_pkg::PVT_T1: if (cnt_reg == 32'h0) begin
        vid_next = 1'b1;
        cnt_next = longer(T5_CYC, T2_CYC);
        st_next = pvt_pkg::PVT_T2;
      end
      pvt_pkg::PVT_T2: begin
        // Backlight wait only starts once the pins really carry video
        if (!live_s2_reg) begin
          cnt_next = longer(T5_CYC, T2_CYC);
        end else if (cnt_reg == 32'h0) begin
          bl_next = 1'b1;
          st_next = pvt_pkg::PVT_LIGHT_ON;
        end
      end
      pvt_pkg::PVT_LIGHT_ON: begin
        rdy_next = 1'b1;
        if (!en_s2_reg) begin
          bl_next = 1'b0;
          rdy_next = 1'b0;
          cnt_next = longer(T6_CYC, T3_CYC);
          st_next = pvt_pkg::PVT_T3;
        end
      end
      pvt_pkg::PVT_T3: if (cnt_reg == 32'h0) begin
        vid_next = 1'b0;
        cnt_next = 32'(T3_CYC);
        st_next = pvt_pkg::PVT_VIDEO_OFF;
      end
      pvt_pkg::PVT_VIDEO_OFF: begin
        // Pixel side lags by a few pixel clocks; t3 counts from the pins going quiet
        if (live_s2_reg) begin
          cnt_next = 32'(T3_CYC);
        end else if (cnt_reg == 32'h0) begin
          sup_next = 1'b0;
          off_cnt_next = 32'(T4_CYC);
          st_next = pvt_pkg::PVT_OFF;
        end
      end
      default: st_next = pvt_pkg::PVT_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_B_IN) begin
      st_reg <= pvt_pkg::PVT_OFF;
      cnt_reg <= 32'h0;
      off_cnt_reg <= 32'h0;
      sup_reg <= 1'b0;
      vid_reg <= 1'b0;
      bl_reg <= 1'b0;
      rdy_reg <= 1'b0;
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      live_s1_reg <= 1'b0;
      live_s2_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      off_cnt_reg <= off_cnt_next;
      sup_reg <= sup_next;
      vid_reg <= vid_next;
      bl_reg <= bl_next;
      rdy_reg <= rdy_next;
      en_s1_reg <= PANEL_ENABLE_IN;
      en_s2_reg <= en_s1_reg;
      live_s1_reg <= live_reg;
      live_s2_reg <= live_s1_reg;
    end
  end

  always_comb begin
    LOGIC_SUPPLY_ON_OUT = sup_reg;
    BACKLIGHT_ON_OUT = bl_reg;
    PANEL_READY_OUT = rdy_reg;
    PIX_READY_OUT = pix_rdy;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel FIFO and video timing (pixel clock)
  logic vid_s1_reg, vid_s2_reg, prst_s1_reg, prst_b;
  logic [10:0] hcnt_reg, hcnt_next;
  logic [10:0] vcnt_reg, vcnt_next;
  logic de_reg, de_next;
  pvt_pkg::pvt_pixel_t px_reg, px_next;
  logic f_valid, f_take;
  pvt_pkg::pvt_pixel_t f_data;

  pvt_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wr_clk_in(REF_CLK_IN),
    .wr_rst_b_in(RST_B_IN),
    .wr_valid_in(PIX_VALID_IN),
    .wr_ready_out(pix_rdy),
    .wr_data_in(PIX_DATA_IN),
    .rd_clk_in(PIXEL_CLOCK_IN),
    .rd_rst_b_in(prst_b),
    .rd_valid_out(f_valid),
    .rd_ready_in(f_take),
    .rd_data_out(f_data)
  );

  always_ff @(posedge PIXEL_CLOCK_IN) begin
    prst_s1_reg <= RST_B_IN;
    prst_b <= prst_s1_reg;
  end

  always_comb begin
    hcnt_next = (hcnt_reg == 11'(LINE_TOTAL - 1)) ? 11'h0 : hcnt_reg + 11'h1;
    vcnt_next = vcnt_reg;
    if (hcnt_reg == 11'(LINE_TOTAL - 1))
      vcnt_next = (vcnt_reg == 11'(FRAME_TOTAL - 1)) ? 11'h0 : vcnt_reg + 11'h1;
    // Enable windows 1280 clocks on each of the first 800 lines
    de_next = vid_s2_reg && hcnt_next < 11'(LINE_ACTIVE)
      && vcnt_next < 11'(FRAME_ACTIVE);
    f_take = de_next;
    // Underrun sends black; idle lines drive zero, never floating
    px_next = (de_next && f_valid) ? f_data : '0;
  end

  always_ff @(posedge PIXEL_CLOCK_IN) begin
    if (!prst_b) begin
      vid_s1_reg <= 1'b0;
      vid_s2_reg <= 1'b0;
      hcnt_reg <= 11'h0;
      vcnt_reg <= 11'h0;
      de_reg <= 1'b0;
      px_reg <= '0;
      live_reg <= 1'b0;
    end else begin
      vid_s1_reg <= vid_reg;
      vid_s2_reg <= vid_s1_reg;
      hcnt_reg <= vid_s2_reg ? hcnt_next : 11'(LINE_TOTAL - 1);
      vcnt_reg <= vid_s2_reg ? vcnt_next : 11'(FRAME_TOTAL - 1);
      de_reg <= de_next;
      px_reg <= px_next;
      live_reg <= vid_s2_reg || de_reg;
    end
  end

  always_comb begin
    ACTIVE_VIDEO_QUALIFIER_OUT = de_reg;
    PIXEL_DATA_OUT = px_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_bl_needs_supply;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN) bl_reg |-> sup_reg && vid_reg;
  endproperty
  a_bl_needs_supply: assert property (p_bl_needs_supply) else $error("backlight without supply");

  property p_bl_off_first;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN) $fell(vid_reg) |-> !bl_reg && !$past(bl_reg);
  endproperty
  a_bl_off_first: assert property (p_bl_off_first) else $error("video dropped with backlight on");

  property p_video_needs_supply;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN) !sup_reg |-> !vid_reg;
  endproperty
  a_video_needs_supply: assert property (p_video_needs_supply) else $error("video without supply");

  property p_t1_wait;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      $rose(sup_reg) |-> !vid_reg [*1] ##0 (st_reg == pvt_pkg::PVT_T1);
  endproperty
  a_t1_wait: assert property (p_t1_wait) else $error("supply rise not followed by t1 wait");

  property p_de_len;
    @(posedge PIXEL_CLOCK_IN) disable iff (!prst_b)
      $rose(de_reg) |-> de_reg && hcnt_reg == 11'h0;
  endproperty
  a_de_len: assert property (p_de_len) else $error("enable starts off line start");

  property p_de_end;
    @(posedge PIXEL_CLOCK_IN) disable iff (!prst_b)
      $fell(de_reg) |-> hcnt_reg == 11'(LINE_ACTIVE) || !vid_s2_reg;
  endproperty
  a_de_end: assert property (p_de_end) else $error("enable width wrong");

  property p_de_lines;
    @(posedge PIXEL_CLOCK_IN) disable iff (!prst_b) de_reg |-> vcnt_reg < 11'(FRAME_ACTIVE);
  endproperty
  a_de_lines: assert property (p_de_lines) else $error("enable outside active lines");

  property p_idle_black;
    @(posedge PIXEL_CLOCK_IN) disable iff (!prst_b) !de_reg |-> px_reg == '0;
  endproperty
  a_idle_black: assert property (p_idle_black) else $error("data not defined while idle");

  property p_bl_after_live;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN) bl_reg |-> live_s2_reg;
  endproperty
  a_bl_after_live: assert property (p_bl_after_live) else $error("backlight before video on pins");

  property p_quiet_before_off;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      $fell(sup_reg) |-> !live_s2_reg && !$past(live_s2_reg);
  endproperty
  a_quiet_before_off: assert property (p_quiet_before_off) else $error("supply off with video live");

  property p_ready_needs_bl;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN) rdy_reg |-> bl_reg;
  endproperty
  a_ready_needs_bl: assert property (p_ready_needs_bl) else $error("ready without backlight");

  property p_restart_wait;
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN) $rose(sup_reg) |-> $past(off_cnt_reg) == 32'h0;
  endproperty
  a_restart_wait: assert property (p_restart_wait) else $error("supply back before off time");

  property p_line_wrap;
    @(posedge PIXEL_CLOCK_IN) disable iff (!prst_b)
      vid_s2_reg && hcnt_reg == 11'(LINE_TOTAL - 1) |=> hcnt_reg == 11'h0;
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line length wrong");

  property p_frame_wrap;
    @(posedge PIXEL_CLOCK_IN) disable iff (!prst_b)
      vid_s2_reg && hcnt_reg == 11'(LINE_TOTAL - 1) && vcnt_reg == 11'(FRAME_TOTAL - 1)
      |=> vcnt_reg == 11'h0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame length wrong");

  c_power_up: cover property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN) $rose(bl_reg));
  c_power_down: cover property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN) $fell(sup_reg));
  c_line: cover property (@(posedge PIXEL_CLOCK_IN) disable iff (!prst_b) $fell(de_reg));
  c_underrun: cover property (@(posedge PIXEL_CLOCK_IN) disable iff (!prst_b)
    de_reg && px_reg == '0);
  c_restart_held: cover property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    en_s2_reg && st_reg == pvt_pkg::PVT_OFF && off_cnt_reg != 32'h0);
endmodule

// *** sim/pvt_panel_model.sv ***
// Panel model that recovers line timing and pixels from the enable alone
module pvt_panel_model (
  // Link
  input wire logic pixel_clock_in,
  input wire logic active_video_qualifier_in,
  input wire pvt_pkg::pvt_pixel_t pixel_in,
  // Observations
  output int active_len_out,
  output int line_len_out,
  output int line_idx_out,
  output int blank_err_out,
  output pvt_pkg::pvt_pixel_t cap_out [0:32]
);
  timeunit 1ns;
  timeprecision 1ps;
  // Low gap longer than any line blank marks a frame blank
  localparam int VBLANK_GAP = 2000;
  int gap = 100000;
  int run = 0;
  int since = 0;
  int col;
  logic de_q = 1'b0;
  logic first_line = 1'b0;
  logic rise;
  assign rise = active_video_qualifier_in && !de_q;
  assign col = rise ? 0 : run;
  always @(posedge pixel_clock_in) begin
    de_q <= active_video_qualifier_in;
    // An unknown enable before the link leaves reset counts as blank
    gap <= (active_video_qualifier_in === 1'b1) ? 0 : gap + 1;
    since <= rise ? 1 : since + 1;
    if (rise) begin
      first_line <= gap > VBLANK_GAP;
      line_idx_out <= (gap > VBLANK_GAP) ? 0 : line_idx_out + 1;
      if (gap <= VBLANK_GAP) begin
        line_len_out <= since;
      end
    end
    if (active_video_qualifier_in) begin
      run <= rise ? 1 : run + 1;
    end
    if (!active_video_qualifier_in && de_q) begin
      active_len_out <= run;
    end
    if (active_video_qualifier_in && (rise ? gap > VBLANK_GAP : first_line) && col <= 32) begin
      cap_out[col] <= pixel_in;
    end
    if (!active_video_qualifier_in && pixel_in != 18'h00000) begin
      blank_err_out <= blank_err_out + 1;
    end
  end
endmodule

// *** sim/pvt_host_tb.sv ***
// Self-checking testbench for the panel host controller
module pvt_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T1 = 20, T2 = 30, T3 = 30, T4 = 60, T5 = 40, T6 = 50;
  localparam int T_BL = (T5 > T2) ? T5 : T2;
  localparam int T_VO = (T6 > T3) ? T6 : T3;
  logic ref_clk = 1'b0;
  logic pclk = 1'b0;
  logic rst_b = 1'b0;
  logic panel_en = 1'b0;
  logic pix_valid = 1'b0;
  pvt_pkg::pvt_pixel_t pix_data = '0;
  logic ready, pix_ready, sup, bl, de;
  pvt_pkg::pvt_pixel_t px_out;
  pvt_pkg::pvt_pixel_t cap [0:32];
  int act_len, line_len, line_idx, blank_err;
  int num_errors = 0;
  int comparisons = 0;
  time ts, tb;
  ////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  initial begin
    #37;
    forever #80 pclk = ~pclk;
  end
  pvt_host #(.T1_CYC(T1), .T2_CYC(T2), .T3_CYC(T3), .T4_CYC(T4), .T5_CYC(T5),
    .T6_CYC(T6)) DUT (.REF_CLK_IN(ref_clk), .RST_B_IN(rst_b), .PIXEL_CLOCK_IN(pclk),
    .PANEL_ENABLE_IN(panel_en), .PANEL_READY_OUT(ready), .PIX_VALID_IN(pix_valid),
    .PIX_READY_OUT(pix_ready), .PIX_DATA_IN(pix_data), .LOGIC_SUPPLY_ON_OUT(sup),
    .BACKLIGHT_ON_OUT(bl), .ACTIVE_VIDEO_QUALIFIER_OUT(de), .PIXEL_DATA_OUT(px_out));
  pvt_panel_model PANEL (.pixel_clock_in(pclk), .active_video_qualifier_in(de),
    .pixel_in(px_out), .active_len_out(act_len), .line_len_out(line_len),
    .line_idx_out(line_idx), .blank_err_out(blank_err), .cap_out(cap));
  ////////////////////////////////////////////////////////////////
  function automatic pvt_pkg::pvt_pixel_t px(input int i);
    return '{red: 6'(i), green: 6'(63 - i), blue: 6'(i * 5)};
  endfunction
  task automatic check_eq(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_min(input string what, input logic [63:0] lo, input logic [63:0] got);
    comparisons++;
    if ((got >= lo) !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %s expected at least %0d seen %0d", what, lo, got);
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check_eq("outputs after reset", 32'h0, 32'({sup, bl, de, ready, px_out}));
    $display("Test reset done");
  endtask
  // Prefill while the panel is off; nothing drains, so the FIFO must refuse at depth
  task automatic t_fill;
    int n;
    n = 0;
    pix_valid <= 1'b1;
    pix_data <= px(0);
    repeat (60) begin
      @(posedge ref_clk);
      if (pix_ready === 1'b1) begin
        n++;
        pix_data <= px(n);
      end
    end
    pix_valid <= 1'b0;
    check_eq("words accepted", 32'd32, 32'(n));
    $display("Test fill done");
  endtask
  task automatic t_power_up;
    @(posedge ref_clk);
    panel_en <= 1'b1;
    for (int i = 0; i < 100 && sup !== 1'b1; i++) @(posedge ref_clk);
    ts = $time;
    check_eq("supply on", 32'h1, 32'(sup));
    check_eq("backlight at supply on", 32'h0, 32'(bl));
    for (int i = 0; i < 300 && bl !== 1'b1; i++) @(posedge ref_clk);
    tb = $time;
    check_min("supply to backlight ns", 64'((T1 + T_BL) * 10), 64'(tb - ts));
    repeat (3) @(posedge ref_clk);
    check_eq("ready", 32'h1, 32'(ready));
    $display("Test power up done");
  endtask
  task automatic t_video;
    for (int i = 0; i < 60000 && line_idx < 1; i++) @(posedge ref_clk);
    check_eq("active cycles", 32'd1280, 32'(act_len));
    check_eq("line cycles", 32'd1440, 32'(line_len));
    for (int i = 0; i < 32; i++) begin
      check_eq("pixel", 32'(px(i)), 32'(cap[i]));
    end
    check_eq("underrun pixel", 32'h0, 32'(cap[32]));
    check_eq("blank data errors", 32'h0, 32'(blank_err));
    $display("Test video done");
  endtask
  // Power down, then ask at once for power up: the restart must wait out the off time
  task automatic t_power_down;
    logic de_seen;
    de_seen = 1'b0;
    @(posedge ref_clk);
    panel_en <= 1'b0;
    for (int i = 0; i < 100 && bl !== 1'b0; i++) @(posedge ref_clk);
    tb = $time;
    check_eq("supply at backlight off", 32'h1, 32'(sup));
    check_eq("ready at backlight off", 32'h0, 32'(ready));
    for (int i = 0; i < 300 && sup !== 1'b0; i++) @(posedge ref_clk);
    ts = $time;
    check_min("backlight off to supply off ns", 64'((T_VO + T3) * 10), 64'(ts - tb));
    panel_en <= 1'b1;
    for (int i = 0; i < 300 && sup !== 1'b1; i++) begin
      @(posedge ref_clk);
      de_seen = de_seen | (de !== 1'b0);
    end
    check_eq("enable while supply off", 32'h0, 32'(de_seen));
    check_min("supply off to on ns", 64'(T4 * 10), 64'($time - ts));
    $display("Test power down done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    // Long enough for three pixel clock edges
    repeat (50) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_fill;
    t_power_up;
    t_video;
    t_power_down;
    complete_run;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    complete_run;
  end
endmodule
